/* rtl/call_unit_pkg.sv */
// shared constants for the conditional call unit
package call_unit_pkg;
	// command byte (upper byte of first dword)
	localparam int CMD_TYPE_HI = 31;
	localparam int CMD_TYPE_LO = 30;
	localparam logic [1:0] TYPE_XFER_CTRL = 2'h2;
	localparam int CMD_OP_HI = 29;
	localparam int CMD_OP_LO = 27;
	localparam logic [2:0] OP_CALL = 3'h1;
	localparam int CMD_PHASE_HI = 26;
	localparam int CMD_PHASE_LO = 24;
	// byte count field bits
	localparam int BIT_REL = 23;
	localparam int BIT_CARRY = 21;
	localparam int BIT_TRUE = 19;
	localparam int BIT_CMP_DATA = 18;
	localparam int BIT_CMP_PHASE = 17;
	localparam int BIT_WAIT = 16;
	localparam int MASK_HI = 15;
	localparam int MASK_LO = 8;
	localparam int DATA_HI = 7;
	localparam int DATA_LO = 0;
	localparam int OFFSET_W = 24;
	// instruction length in bytes
	localparam logic [31:0] INSTR_BYTES = 32'h0000_0008;
	// apb register offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FIRST_BYTE = 8'h08;
	localparam logic [7:0] ADDR_RETURN = 8'h0C;
	localparam logic [7:0] ADDR_POINTER = 8'h10;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam int CTRL_TARGET = 0;
	localparam int CTRL_CARRY = 1;
	// machine states
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_EVAL = 2'b10
	} state_t;
endpackage

/* rtl/call_condition.sv */
// combinational condition evaluator for the call instruction
module call_condition
(
	input wire logic [31:0] i_first_dword,
	input wire logic [2:0] i_phase,
	input wire logic i_attention,
	input wire logic i_target_role,
	input wire logic [7:0] i_first_received_byte,
	input wire logic i_carry,
	output logic o_take
);
	wire logic [7:0] mask;
	wire logic [7:0] data;
	wire logic [7:0] diff;
	wire logic phase_ok;
	wire logic data_ok;
	wire logic cond;
	assign mask = i_first_dword[call_unit_pkg::MASK_HI:call_unit_pkg::MASK_LO];
	assign data = i_first_dword[call_unit_pkg::DATA_HI:call_unit_pkg::DATA_LO];
	// set mask bits are ignored
	assign diff = (i_first_received_byte ^ data) & ~mask;
	// phase bits msg, c/d, i/o against live lines; atn in target role
	assign phase_ok = !i_first_dword[call_unit_pkg::BIT_CMP_PHASE] ||
		(i_target_role ? i_attention : (i_phase == i_first_dword[
		call_unit_pkg::CMD_PHASE_HI:call_unit_pkg::CMD_PHASE_LO]));
	assign data_ok = !i_first_dword[call_unit_pkg::BIT_CMP_DATA] ||
		(diff == 8'h00);
	// carry test alone overrides the other compares
	assign cond = i_first_dword[call_unit_pkg::BIT_CARRY] ? i_carry :
		(phase_ok && data_ok);
	assign o_take = (cond == i_first_dword[call_unit_pkg::BIT_TRUE]);
endmodule

/* rtl/conditional_call_unit.sv */
// conditional subroutine call decoder and executor with apb registers
//
// Design decisions made here: the register offsets and the APB interface to the registers.
module conditional_call_unit
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_instr_valid,
	input wire logic [31:0] i_first_dword,
	input wire logic [31:0] i_second_dword,
	input wire logic [2:0] i_phase_lines,
	input wire logic i_attention_line,
	input wire logic i_target_request_line,
	input wire logic i_carry_flag,
	input wire logic i_byte_received,
	input wire logic [7:0] i_received_byte,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_busy,
	output logic o_done,
	output logic o_taken,
	output logic [31:0] o_script_pointer,
	output logic [31:0] o_return_address
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers
	// two flops before any logic reads the pins
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	wire logic [2:0] phase_s;
	wire logic atn_s;
	wire logic req_s;
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
		end
		else if (i_ce)
		begin
			pin_meta_q <= {i_target_request_line, i_attention_line,
				i_phase_lines};
			pin_sync_q <= pin_meta_q;
		end
	end
	assign phase_s = pin_sync_q[2:0];
	assign atn_s = pin_sync_q[3];
	assign req_s = pin_sync_q[4];

	////////////////////////////////////////////////////////////////
	// registers
	call_unit_pkg::state_t state_q;
	call_unit_pkg::state_t state_d;
	logic [31:0] instr_q;
	logic [31:0] operand_q;
	logic [31:0] pointer_q;
	logic [31:0] return_q;
	logic [7:0] first_byte_q;
	logic [1:0] ctrl_q;
	logic done_q;
	logic taken_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic busy_q;

	////////////////////////////////////////////////////////////////
	// decode
	wire logic is_call;
	wire logic take;
	wire logic relative_keyword;
	wire logic [31:0] next_seq;
	wire logic [31:0] rel_target;
	wire logic [31:0] target;
	assign is_call = (i_first_dword[call_unit_pkg::CMD_TYPE_HI:
		call_unit_pkg::CMD_TYPE_LO] == call_unit_pkg::TYPE_XFER_CTRL)
		&& (i_first_dword[call_unit_pkg::CMD_OP_HI:call_unit_pkg::CMD_OP_LO]
		== call_unit_pkg::OP_CALL);
	assign relative_keyword = instr_q[call_unit_pkg::BIT_REL];
	assign next_seq = pointer_q + call_unit_pkg::INSTR_BYTES;
	// offset sign-extended so backward calls work
	// base is the next sequential address, the pointer plus eight bytes
	assign rel_target = next_seq + {{8{operand_q[23]}},
		operand_q[call_unit_pkg::OFFSET_W-1:0]};
	assign target = relative_keyword ? rel_target : operand_q;
	// other types and opcodes pass untouched; only calls start the machine

	call_condition u_cond
	(
		.i_first_dword(instr_q),
		.i_phase(phase_s),
		.i_attention(atn_s),
		.i_target_role(ctrl_q[call_unit_pkg::CTRL_TARGET]),
		.i_first_received_byte(first_byte_q),
		.i_carry(i_carry_flag | ctrl_q[call_unit_pkg::CTRL_CARRY]),
		.o_take(take)
	);

	////////////////////////////////////////////////////////////////
	// sequencer
	wire logic start;
	wire logic eval_now;
	// a request while busy is dropped with no error flagged
	assign start = (state_q == call_unit_pkg::ST_IDLE) && i_instr_valid
		&& is_call;
	assign eval_now = (state_q == call_unit_pkg::ST_EVAL) ||
		((state_q == call_unit_pkg::ST_WAIT) && req_s);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			call_unit_pkg::ST_IDLE:
			begin
				if (start)
					state_d = i_first_dword[call_unit_pkg::BIT_WAIT] ?
						call_unit_pkg::ST_WAIT : call_unit_pkg::ST_EVAL;
			end
			call_unit_pkg::ST_WAIT:
			begin
				if (req_s)
					state_d = call_unit_pkg::ST_IDLE;
			end
			call_unit_pkg::ST_EVAL:
				state_d = call_unit_pkg::ST_IDLE;
			default:
				state_d = call_unit_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state_q <= call_unit_pkg::ST_IDLE;
			instr_q <= call_unit_pkg::RESET_WORD;
			operand_q <= call_unit_pkg::RESET_WORD;
		end
		else if (i_ce)
		begin
			state_q <= state_d;
			// operands latched so the source may move on while we wait
			if (start)
			begin
				instr_q <= i_first_dword;
				operand_q <= i_second_dword;
			end
		end
	end

	// busy from a flop so the port carries no decode glitches
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			busy_q <= 1'b0;
		else if (i_ce)
			busy_q <= (state_d != call_unit_pkg::ST_IDLE);
	end

	// pointer and single return slot
	wire logic sw_ptr_wr;
	wire logic sw_ret_wr;
	wire logic sw_byte_wr;
	wire logic sw_ctrl_wr;
	wire logic access;
	wire logic commit;
	assign access = i_psel && i_penable && !pready_q;
	// writes land on the completing edge, where pready is seen high
	assign commit = i_psel && i_penable && pready_q;
	assign sw_ptr_wr = commit && i_pwrite &&
		(i_paddr == call_unit_pkg::ADDR_POINTER);
	assign sw_ret_wr = commit && i_pwrite &&
		(i_paddr == call_unit_pkg::ADDR_RETURN);
	assign sw_byte_wr = commit && i_pwrite &&
		(i_paddr == call_unit_pkg::ADDR_FIRST_BYTE);
	assign sw_ctrl_wr = commit && i_pwrite &&
		(i_paddr == call_unit_pkg::ADDR_CTRL);

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pointer_q <= call_unit_pkg::RESET_WORD;
			return_q <= call_unit_pkg::RESET_WORD;
			done_q <= 1'b0;
			taken_q <= 1'b0;
		end
		else if (i_ce)
		begin
			done_q <= eval_now;
			if (eval_now)
			begin
				taken_q <= take;
				if (take)
				begin
					return_q <= next_seq;
					pointer_q <= target;
				end
				else
					pointer_q <= next_seq;
			end
			else
			begin
				// hardware update wins over software in same cycle
				if (sw_ptr_wr)
					pointer_q <= i_pwdata;
				if (sw_ret_wr)
					return_q <= i_pwdata;
			end
		end
	end

	// first received byte, hardware capture wins over software
	// the capture strobe comes from logic on this clock, so no sync
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			first_byte_q <= 8'h00;
		else if (i_ce)
		begin
			if (i_byte_received)
				first_byte_q <= i_received_byte;
			else if (sw_byte_wr)
				first_byte_q <= i_pwdata[7:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ctrl_q <= 2'h0;
		else if (i_ce && sw_ctrl_wr)
			ctrl_q <= i_pwdata[1:0];
	end

	////////////////////////////////////////////////////////////////
	// apb slave: one wait state, unmapped reads zero with slverr
	wire logic mapped;
	wire logic [31:0] rdata_d;
	assign mapped = (i_paddr == call_unit_pkg::ADDR_CTRL) ||
		(i_paddr == call_unit_pkg::ADDR_STATUS) ||
		(i_paddr == call_unit_pkg::ADDR_FIRST_BYTE) ||
		(i_paddr == call_unit_pkg::ADDR_RETURN) ||
		(i_paddr == call_unit_pkg::ADDR_POINTER);
	assign rdata_d =
		(i_paddr == call_unit_pkg::ADDR_CTRL) ? {30'h0, ctrl_q} :
		(i_paddr == call_unit_pkg::ADDR_STATUS) ?
			{28'h0, taken_q, state_q, state_q != call_unit_pkg::ST_IDLE} :
		(i_paddr == call_unit_pkg::ADDR_FIRST_BYTE) ?
			{24'h0, first_byte_q} :
		(i_paddr == call_unit_pkg::ADDR_RETURN) ? return_q :
		(i_paddr == call_unit_pkg::ADDR_POINTER) ? pointer_q : 32'h0;

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= call_unit_pkg::RESET_WORD;
		end
		else if (i_ce)
		begin
			pready_q <= access;
			pslverr_q <= access && !mapped;
			// zero outside the answer cycle so reads leave no trace
			prdata_q <= (access && !i_pwrite) ? rdata_d : 32'h0;
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_busy = busy_q;
	assign o_done = done_q;
	assign o_taken = taken_q;
	assign o_script_pointer = pointer_q;
	assign o_return_address = return_q;
endmodule

/* testbench/call_unit_assertions.sv */
// concurrent checks on the call unit ports
module call_unit_assertions
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_instr_valid,
	input wire logic [31:0] i_first_dword,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_taken,
	input wire logic [31:0] o_script_pointer,
	input wire logic [31:0] o_return_address
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	wire logic go = i_ce && i_instr_valid && !o_busy;
	wire logic is_call = i_first_dword[31:27] == 5'h11;
	////////////////////////////////////////////////////////////////////
	call_latency_a: assert property (
		go && is_call && !i_first_dword[16] ##1 i_ce |=> o_done)
		else $error("immediate call did not finish in two cycles");
	other_type_a: assert property (
		go && i_first_dword[31:30] != 2'h2 |=> !o_busy)
		else $error("non transfer control instruction started");
	ret_slot_a: assert property (
		o_done && o_taken
		|-> o_return_address == $past(o_script_pointer) + 32'h8)
		else $error("return slot not next sequential address");
	seq_next_a: assert property (
		o_done && !o_taken
		|-> o_script_pointer == $past(o_script_pointer) + 32'h8)
		else $error("pointer not on next instruction");
	done_pulse_a: assert property (o_done |=> !o_done)
		else $error("done longer than one cycle");
	ready_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	ready_access_a: assert property (o_pready |-> i_psel && i_penable)
		else $error("pready outside access phase");
	err_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("pslverr without pready");
endmodule

/* testbench/bus_peer.sv */
// model of the far bus peer: phase, attention, request, bytes
module bus_peer
(
	input wire logic i_clk,
	output logic [2:0] o_phase = 3'h0,
	output logic o_atn = 1'b0,
	output logic o_req = 1'b0,
	output logic o_strobe = 1'b0,
	output logic [7:0] o_byte = 8'h5A
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic bus(input logic [2:0] p, input logic a);
		@(posedge i_clk);
		o_phase <= p;
		o_atn <= a;
	endtask
	// data is stale outside the strobe, so never left holding
	task automatic send(input logic [7:0] b);
		@(posedge i_clk);
		o_strobe <= 1'b1;
		o_byte <= b;
		@(posedge i_clk);
		o_strobe <= 1'b0;
		o_byte <= ~b;
	endtask
	task automatic req_after(input int d);
		repeat (d) @(posedge i_clk);
		o_req <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_req <= 1'b0;
	endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the conditional call unit
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [31:0] f, s; logic [2:0] pl;
		logic [7:0] b; logic c, tk;} row_t;
	logic i_clk, i_sys_rst, i_ce, i_instr_valid, i_carry_flag;
	logic i_psel, i_penable, i_pwrite, i_byte_received;
	logic i_attention_line, i_target_request_line, o_busy;
	logic [7:0] i_paddr, i_received_byte;
	logic [2:0] i_phase_lines;
	logic [31:0] i_first_dword, i_second_dword, i_pwdata;
	logic [31:0] o_prdata, o_script_pointer, o_return_address;
	logic o_pready, o_pslverr, o_done, o_taken, e;
	logic [31:0] ptr, ret, r;
	int fails, samples_checked;
	row_t rows[11];
	conditional_call_unit u_conditional_call_unit (.*);
	bus_peer u_bus_peer (.i_clk(i_clk), .o_phase(i_phase_lines),
		.o_atn(i_attention_line), .o_req(i_target_request_line),
		.o_strobe(i_byte_received), .o_byte(i_received_byte));
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] mk(input logic [7:0] c,
		input logic [2:0] ph, input logic [7:0] m, d);
		return {5'h11, ph, c, m, d};
	endfunction
	task automatic chk(input logic [31:0] g, x);
		samples_checked++;
		if (g !== x)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_clk);
		{i_psel, i_penable, i_pwrite} <= {2'b10, w};
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		@(negedge i_clk);
		while (o_pready !== 1'b1)
			@(negedge i_clk);
		r = o_prdata;
		e = o_pslverr;
		@(posedge i_clk);
		{i_psel, i_penable} <= 2'b00;
	endtask
	task automatic run(input logic [31:0] f, s, input logic tk);
		logic [31:0] old;
		old = ptr;
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_first_dword <= f;
		i_second_dword <= s;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		for (int k = 0; k < 60 && o_done !== 1'b1; k++)
			@(negedge i_clk);
		ret = tk ? old + 32'h8 : ret;
		ptr = !tk ? old + 32'h8 : !f[23] ? s
			: old + 32'h8 + {{8{s[23]}}, s[23:0]};
		chk(o_done, 1);
		chk(o_taken, tk);
		chk(o_script_pointer, ptr);
		chk(o_return_address, ret);
	endtask
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		fails++;
		$display("unexpected at %0t: run hung", $time);
		complete_run;
	end
	initial
	begin
		{i_sys_rst, i_ce, i_instr_valid, i_carry_flag} = 4'hC;
		{i_psel, i_penable, i_pwrite, i_paddr} = '0;
		{i_first_dword, i_second_dword, i_pwdata} = '0;
		{fails, samples_checked, ret} = '0;
		rows[0] = '{mk(8'h08, 0, 0, 0), 32'h2000, 0, 0, 0, 1};
		rows[1] = '{mk(8'h0A, 7, 0, 0), 32'h2100, 7, 0, 0, 1};
		rows[2] = '{mk(8'h0A, 6, 0, 0), 32'h2200, 7, 0, 0, 0};
		rows[3] = '{mk(8'h02, 6, 0, 0), 32'h2300, 7, 0, 0, 1};
		rows[4] = '{mk(8'h0C, 0, 8'h0F, 8'hA5), 32'h2400, 0, 8'hA3, 0, 1};
		rows[5] = '{mk(8'h0C, 0, 8'h0F, 8'hA5), 32'h2500, 0, 8'h53, 0, 0};
		rows[6] = '{mk(8'h0E, 2, 0, 8'h11), 32'h2600, 2, 8'h12, 0, 0};
		rows[7] = '{mk(8'h0E, 2, 0, 8'h12), 32'h2700, 2, 8'h12, 0, 1};
		rows[8] = '{mk(8'h28, 0, 0, 0), 32'h2800, 0, 8'h12, 1, 1};
		rows[9] = '{mk(8'h28, 0, 0, 0), 32'h2900, 0, 8'h12, 0, 0};
		rows[10] = '{mk(8'h88, 0, 0, 0), 32'hFFFFF0, 0, 8'h12, 0, 1};
		repeat (12) @(posedge i_clk);
		chk({o_busy, o_done, o_taken, o_pready, o_pslverr}, 0);
		chk(o_script_pointer | o_return_address | o_prdata, 0);
		i_sys_rst <= 1'b0;
		$display("reset test done");
		ptr = 32'h100;
		apb(1, call_unit_pkg::ADDR_POINTER, ptr);
		apb(0, call_unit_pkg::ADDR_POINTER, 0);
		chk(r, ptr);
		apb(0, 8'h14, 0);
		chk({e, r}, {1'b1, 32'h0});
		foreach (rows[i])
		begin
			u_bus_peer.bus(rows[i].pl, 0);
			u_bus_peer.send(rows[i].b);
			i_carry_flag <= rows[i].c;
			repeat (4) @(posedge i_clk);
			run(rows[i].f, rows[i].s, rows[i].tk);
		end
		apb(0, call_unit_pkg::ADDR_FIRST_BYTE, 0);
		chk(r, 32'h12);
		$display("row tests done");
		for (int p = 0; p < 8; p++)
		begin
			u_bus_peer.bus(p[2:0], 0);
			repeat (4) @(posedge i_clk);
			run(mk(8'h0A, 3'h5, 0, 0), 32'h300, p == 5);
		end
		apb(1, call_unit_pkg::ADDR_CTRL, 1);
		u_bus_peer.bus(3'h0, 1);
		repeat (4) @(posedge i_clk);
		run(mk(8'h0A, 3'h7, 0, 0), 32'h400, 1);
		apb(1, call_unit_pkg::ADDR_CTRL, 0);
		u_bus_peer.bus(3'h7, 0);
		fork
			u_bus_peer.req_after(20);
			run(mk(8'h0B, 3'h7, 0, 0), 32'h500, 1);
			begin
				repeat (12) @(negedge i_clk);
				chk(o_busy, 1);
			end
		join
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_first_dword <= mk(8'h0B, 3'h7, 0, 0);
		i_second_dword <= 32'h700;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		i_ce <= 1'b0;
		u_bus_peer.req_after(1);
		repeat (4) @(negedge i_clk);
		chk({o_busy, o_done, o_taken}, 3'h5);
		chk(o_script_pointer, ptr);
		@(posedge i_clk);
		i_ce <= 1'b1;
		ret = ptr + 32'h8;
		ptr = 32'h700;
		fork
			u_bus_peer.req_after(1);
			begin
				repeat (5) @(negedge i_clk);
				chk({o_done, o_taken}, 2'h3);
				chk(o_script_pointer, ptr);
				chk(o_return_address, ret);
			end
		join
		$display("clock enable test done");
		apb(1, call_unit_pkg::ADDR_STATUS, 32'hF);
		apb(0, call_unit_pkg::ADDR_STATUS, 0);
		chk({e, r}, {1'b0, 32'h8});
		apb(1, call_unit_pkg::ADDR_CTRL, 2);
		apb(0, call_unit_pkg::ADDR_CTRL, 0);
		chk(r, 2);
		run(mk(8'h28, 0, 0, 0), 32'h600, 1);
		apb(1, call_unit_pkg::ADDR_CTRL, 0);
		ret = 32'hABCD_0000;
		apb(1, call_unit_pkg::ADDR_RETURN, ret);
		apb(0, call_unit_pkg::ADDR_RETURN, 0);
		chk(r, ret);
		$display("register tests done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge i_clk);
			i_instr_valid <= 1'b1;
			i_first_dword <= k ? 32'h0808_0000 : 32'h8008_0000;
			@(posedge i_clk);
			i_instr_valid <= 1'b0;
			repeat (3) @(negedge i_clk);
			chk(o_busy, 0);
		end
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_first_dword <= mk(8'h0B, 3'h7, 0, 0);
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		i_sys_rst <= 1'b1;
		repeat (2) @(negedge i_clk);
		chk({o_busy, o_done, o_taken, o_pready, o_pslverr}, 0);
		chk(o_script_pointer | o_return_address | o_prdata, 0);
		@(posedge i_clk);
		i_sys_rst <= 1'b0;
		ptr = 32'h0;
		ret = 32'h0;
		@(negedge i_clk);
		chk(o_busy, 0);
		run(mk(8'h08, 0, 0, 0), 32'h800, 1);
		$display("mid-run reset test done");
		$display("awkward tests done");
		complete_run;
	end
endmodule
bind conditional_call_unit call_unit_assertions u_chk (.*);
